// >>> hdl/wake_pattern_frame_detector.sv
// wake pattern frame detector: scans received bytes for the wake sequence
// assumes rx bytes and end-of-frame status are synchronous to clk
`timescale 1ns/1ps

// Behaviour
// RQ1 - match only while wake mode enabled
// RQ2 - examine every frame addressed to node
// RQ3 - frame needs address acceptance and good FCS
// RQ4 - broadcast frames qualify when copies match
// RQ5 - sync run of six 0xff bytes
// RQ6 - sixteen unbroken copies of station address
// RQ7 - sequence may start anywhere in frame
// RQ8 - payload protocol is not inspected
// RQ9 - no sequence means no alert
// RQ10 - full sequence raises wake alert
// RQ11 - mismatch restarts, current byte reconsidered
// RQ12 - alert only at good end of frame
module wake_pattern_frame_detector
   import wake_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        wake_en,
   input  wire logic [47:0] station_addr,
   input  wire rx_byte_t    rx,
   input  wire rx_status_t  rx_stat,
   output logic             wake_alert
);

   match_state_t state_q, state_d;
   logic [2:0]   sync_cnt_q, sync_cnt_d;
   logic [2:0]   idx_q, idx_d;
   logic [4:0]   copy_q, copy_d;
   logic         found_q, found_d;
   logic         alert_q, alert_d;
   logic         seq_hit;

   // byte i of the station address, first transmitted byte is the top octet
   function automatic logic [7:0] addr_byte(input logic [47:0] a, input logic [2:0] i);
      addr_byte = a[BYTE_W * (ADDR_BYTES - 1 - int'(i)) +: BYTE_W];
   endfunction

   function automatic logic is_sync(input logic [7:0] b);
      is_sync = (b == SYNC_BYTE);
   endfunction

   always_comb begin
      state_d    = state_q;
      sync_cnt_d = sync_cnt_q;
      idx_d      = idx_q;
      copy_d     = copy_q;
      found_d    = found_q;
      alert_d    = 1'b0;
      seq_hit    = 1'b0;
      if (!wake_en) begin                                    // RQ1
         state_d    = ST_SYNC;
         sync_cnt_d = IDX_ZERO;
         found_d    = 1'b0;
      end else if (rx.valid) begin
         if (rx.sof) begin                                   // RQ2
            state_d    = ST_SYNC;
            sync_cnt_d = IDX_ZERO;
            idx_d      = IDX_ZERO;
            copy_d     = COPY_ZERO;
            found_d    = 1'b0;
         end
         // raw byte scan with no protocol parsing, starting at any offset
         case (rx.sof ? ST_SYNC : state_q)                   // RQ7 RQ8
            ST_SYNC: begin
               if (is_sync(rx.data)) begin                   // RQ5
                  if ((rx.sof ? IDX_ZERO : sync_cnt_q) == SYNC_LAST) begin
                     state_d = ST_ADDR;
                     idx_d   = IDX_ZERO;
                     copy_d  = COPY_ZERO;
                  end else begin
                     sync_cnt_d = (rx.sof ? IDX_ZERO : sync_cnt_q) + 3'h1;
                  end
               end else begin
                  sync_cnt_d = IDX_ZERO;
               end
            end
            ST_ADDR: begin
               if (rx.data == addr_byte(station_addr, idx_q)) begin  // RQ6
                  if (idx_q == IDX_LAST) begin
                     idx_d = IDX_ZERO;
                     if (copy_q == COPY_LAST) begin
                        state_d = ST_DONE;
                        found_d = 1'b1;
                     end else begin
                        copy_d = copy_q + 5'h01;
                     end
                  end else begin
                     idx_d = idx_q + 3'h1;
                  end
               end else if (is_sync(rx.data)) begin          // RQ11
                  // extra 0xff ahead of the address keeps the run alive;
                  // otherwise this byte opens a fresh run
                  state_d    = (idx_q == IDX_ZERO && copy_q == COPY_ZERO) ? ST_ADDR : ST_SYNC;
                  sync_cnt_d = 3'h1;
                  idx_d      = IDX_ZERO;
                  copy_d     = COPY_ZERO;
               end else begin
                  state_d    = ST_SYNC;                      // RQ11
                  sync_cnt_d = IDX_ZERO;
                  idx_d      = IDX_ZERO;
                  copy_d     = COPY_ZERO;
               end
            end
            ST_DONE: ;
            default: state_d = ST_SYNC;
         endcase
         if (rx.eof) begin
            // the eof byte itself may complete the sequence, so judge the flag first
            seq_hit    = found_d;                                     // RQ9
            // addr_ok covers own, multicast and broadcast destinations
            alert_d    = seq_hit & rx_stat.addr_ok & rx_stat.fcs_ok;  // RQ12 RQ3 RQ4 RQ10
            state_d    = ST_SYNC;
            sync_cnt_d = IDX_ZERO;
            found_d    = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q    <= ST_SYNC;
         sync_cnt_q <= IDX_ZERO;
         idx_q      <= IDX_ZERO;
         copy_q     <= COPY_ZERO;
         found_q    <= 1'b0;
         alert_q    <= 1'b0;
      end else begin
         state_q    <= state_d;
         sync_cnt_q <= sync_cnt_d;
         idx_q      <= idx_d;
         copy_q     <= copy_d;
         found_q    <= found_d;
         alert_q    <= alert_d;
      end
   end

   assign wake_alert = alert_q;

   a_alert_needs_eof: assert property ( // RQ12
      @(posedge clk) disable iff (!rst_b)
      wake_alert |-> $past(rx.valid && rx.eof && rx_stat.fcs_ok && rx_stat.addr_ok))
      else $error("alert without good end of frame");

   a_alert_needs_en: assert property ( // RQ1
      @(posedge clk) disable iff (!rst_b)
      wake_alert |-> $past(wake_en))
      else $error("alert while wake mode off");

   // reads the match state itself so that it does not lean on seq_hit
   a_alert_needs_match: assert property ( // RQ10
      @(posedge clk) disable iff (!rst_b)
      wake_alert |-> $past(state_q == ST_DONE ||
         (state_q == ST_ADDR && idx_q == IDX_LAST && copy_q == COPY_LAST)))
      else $error("alert without full sequence");

   a_no_alert_nomatch: assert property ( // RQ9
      @(posedge clk) disable iff (!rst_b)
      (rx.valid && rx.eof && !seq_hit) |=> !wake_alert)
      else $error("alert on frame without sequence");

   a_good_match_alerts: assert property ( // RQ10
      @(posedge clk) disable iff (!rst_b)
      (wake_en && rx.valid && rx.eof && seq_hit && rx_stat.fcs_ok && rx_stat.addr_ok)
      |=> wake_alert)
      else $error("missed wake alert");

   a_bad_fcs_quiet: assert property ( // RQ3
      @(posedge clk) disable iff (!rst_b)
      (rx.valid && rx.eof && !rx_stat.fcs_ok) |=> !wake_alert)
      else $error("alert on errored frame");

   a_bad_addr_quiet: assert property ( // RQ3
      @(posedge clk) disable iff (!rst_b)
      (rx.valid && rx.eof && !rx_stat.addr_ok) |=> !wake_alert)
      else $error("alert on rejected destination");

   a_sync_to_addr: assert property ( // RQ5
      @(posedge clk) disable iff (!rst_b)
      (wake_en && rx.valid && !rx.sof && !rx.eof && state_q == ST_SYNC
       && sync_cnt_q == SYNC_LAST && is_sync(rx.data)) |=> state_q == ST_ADDR)
      else $error("sync run not accepted");

   a_sync_break: assert property ( // RQ5
      @(posedge clk) disable iff (!rst_b)
      (wake_en && rx.valid && !rx.sof && !rx.eof && state_q == ST_SYNC
       && !is_sync(rx.data)) |=> (state_q == ST_SYNC && sync_cnt_q == IDX_ZERO))
      else $error("broken sync run kept counting");

   a_mismatch_restart: assert property ( // RQ11
      @(posedge clk) disable iff (!rst_b)
      (wake_en && rx.valid && !rx.sof && !rx.eof && state_q == ST_ADDR
       && rx.data != addr_byte(station_addr, idx_q) && !is_sync(rx.data))
      |=> state_q == ST_SYNC && copy_q == COPY_ZERO)
      else $error("mismatch did not restart");

   a_alert_one_cycle: assert property ( // RQ10
      @(posedge clk) disable iff (!rst_b)
      wake_alert |=> !wake_alert)
      else $error("alert stretched");

   a_off_clears: assert property ( // RQ1
      @(posedge clk) disable iff (!rst_b)
      !wake_en |=> (state_q == ST_SYNC && !found_q))
      else $error("matcher kept state while wake mode off");

   a_sof_restart: assert property ( // RQ2
      @(posedge clk) disable iff (!rst_b)
      (wake_en && rx.valid && rx.sof && !is_sync(rx.data))
      |=> (state_q == ST_SYNC && sync_cnt_q == IDX_ZERO && !found_q))
      else $error("new frame did not restart the matcher");

   a_done_holds: assert property ( // RQ10
      @(posedge clk) disable iff (!rst_b)
      (wake_en && state_q == ST_DONE && !(rx.valid && (rx.sof || rx.eof)))
      |=> (state_q == ST_DONE && found_q))
      else $error("found sequence lost before end of frame");


   c_match_found: cover property (@(posedge clk) disable iff (!rst_b) state_q == ST_DONE);
   c_alert: cover property (@(posedge clk) disable iff (!rst_b) wake_alert);
   c_restart: cover property (@(posedge clk) disable iff (!rst_b)
      state_q == ST_ADDR ##1 state_q == ST_SYNC);
   c_bad_frame_drop: cover property (@(posedge clk) disable iff (!rst_b)
      rx.valid && rx.eof && seq_hit && !rx_stat.fcs_ok);
   c_extra_sync: cover property (@(posedge clk) disable iff (!rst_b)
      rx.valid && state_q == ST_ADDR && idx_q == IDX_ZERO && copy_q == COPY_ZERO
      && is_sync(rx.data));
endmodule

// >>> hdl/wake_pkg.sv
// shared constants and carrier types for the wake pattern frame detector
// assumes a byte-wide receive stream with one valid strobe per byte
package wake_pkg;
   localparam int          BYTE_W     = 8;
   localparam int          ADDR_BYTES = 6;
   localparam int          SYNC_BYTES = 6;
   localparam int          COPIES     = 16;
   localparam logic [7:0]  SYNC_BYTE  = 8'hff;
   localparam logic [2:0]  IDX_ZERO   = 3'h0;
   localparam logic [2:0]  IDX_LAST   = 3'h5;
   localparam logic [2:0]  SYNC_LAST  = 3'h5;
   localparam logic [4:0]  COPY_ZERO  = 5'h00;
   localparam logic [4:0]  COPY_LAST  = 5'h0f;

   // one received byte with frame markers
   typedef struct packed {
      logic       valid;
      logic       sof;
      logic       eof;
      logic [7:0] data;
   } rx_byte_t;

   // verdict of the receive path on the frame that just ended
   typedef struct packed {
      logic addr_ok;
      logic fcs_ok;
   } rx_status_t;

   typedef enum logic [2:0] {
      ST_SYNC = 3'b001,
      ST_ADDR = 3'b010,
      ST_DONE = 3'b100
   } match_state_t;
endpackage

// >>> test/rx_source.sv
// receive path model: plays one stored frame byte by byte into the detector
// assumes the bench loads mem and calls send only between frames
`timescale 1ns/1ps
module rx_source
   import wake_pkg::*;
(
   input  wire logic clk,
   output rx_byte_t   rx,
   output rx_status_t rx_stat
);
   logic [7:0] mem [0:255];
   initial begin
      rx      = '0;
      rx_stat = '0;
   end
   // idle data and status are inverted so a stale value never looks current
   task automatic send(input int n, input logic [1:0] st, input int gap);
      for (int i = 0; i < n; i++) begin
         for (int g = 0; g < gap; g++) begin
            @(posedge clk);
            #1 rx = '{1'b0, 1'b0, 1'b0, ~rx.data};
         end
         @(posedge clk);
         #1 rx = '{1'b1, i == 0, i == n - 1, mem[i]};
         rx_stat = (i == n - 1) ? st : ~st;
      end
      @(posedge clk);
      #1 rx = '{1'b0, 1'b0, 1'b0, ~rx.data};
      rx_stat = ~st;
   endtask
endmodule

// >>> test/tb_top.sv
// self-checking bench for the wake pattern frame detector
// assumes rx_source as the receive path and wake_pkg compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
   import wake_pkg::*;
   logic        clk          = 1'b0;
   logic        rst_b        = 1'b0;
   logic        wake_en      = 1'b1;
   logic [47:0] station_addr = 48'h02a4_5c19_e7b3;
   rx_byte_t    rx;
   rx_status_t  rx_stat;
   logic        wake_alert;
   int          err_count    = 0;
   int          comparisons  = 0;
   int          n            = 0;
   int          hits         = 0;
   always #2 clk = ~clk;
   always @(posedge clk) if (wake_alert === 1'b1) hits++;
   rx_source rx_source_inst (.clk(clk), .rx(rx), .rx_stat(rx_stat));
   wake_pattern_frame_detector wake_pattern_frame_detector_inst (.clk(clk), .rst_b(rst_b),
      .wake_en(wake_en), .station_addr(station_addr), .rx(rx), .rx_stat(rx_stat),
      .wake_alert(wake_alert));
   task automatic put(input logic [7:0] b);
      rx_source_inst.mem[n] = b;
      n++;
   endtask
   task automatic copies(input int k);
      for (int c = 0; c < k; c++)
         for (int i = 0; i < 6; i++) put(station_addr[47 - 8 * i -: 8]);
   endtask
   // brk plants a sync run and three copies cut short by an extra 0xff byte
   task automatic frame(input bit bc, input bit brk, input int ffs, input int k,
                        input int tail, input logic [1:0] st, input int gap, input logic ex);
      int h0;
      h0 = hits;
      n = 0;
      for (int i = 0; i < 6; i++) put(bc ? SYNC_BYTE : station_addr[47 - 8 * i -: 8]);
      put(8'h08);
      put(8'h00);
      if (brk) begin
         repeat (6) put(SYNC_BYTE);
         copies(3);
         put(SYNC_BYTE);
      end
      repeat (ffs) put(SYNC_BYTE);
      copies(k);
      repeat (tail) put(8'h5a);
      rx_source_inst.send(n, st, gap);
      `CHK(wake_alert, ex)
      @(posedge clk);
      #1;
      `CHK(wake_alert, 1'b0)
      `CHK(hits - h0, 32'(ex))
   endtask
   task automatic t_basic();
      frame(0, 0, 7, 16, 4, 2'b11, 0, 1'b1);
      frame(1, 0, 6, 16, 0, 2'b11, 1, 1'b1);
      $display("test basic done");
   endtask
   task automatic t_refuse();
      for (int s = 0; s < 3; s++) frame(0, 0, 6, 16, 4, 2'(s), 0, 1'b0);
      frame(0, 0, 6, 15, 4, 2'b11, 0, 1'b0);
      frame(0, 0, 5, 16, 4, 2'b11, 0, 1'b0);
      $display("test refuse done");
   endtask
   task automatic t_restart();
      frame(0, 1, 5, 16, 4, 2'b11, 0, 1'b1);
      $display("test restart done");
   endtask
   // broadcast frame whose copies name another node must not wake this one
   task automatic t_foreign();
      int h0;
      h0 = hits;
      n = 0;
      repeat (12) put(SYNC_BYTE);
      copies(16);
      station_addr = station_addr ^ 48'h0000_0000_0001;
      rx_source_inst.send(n, 2'b11, 0);
      `CHK(wake_alert, 1'b0)
      @(posedge clk);
      #1;
      `CHK(hits - h0, 0)
      station_addr = station_addr ^ 48'h0000_0000_0001;
      $display("test foreign done");
   endtask
   task automatic t_off();
      int h0;
      wake_en = 1'b0;
      frame(0, 0, 6, 16, 4, 2'b11, 0, 1'b0);
      wake_en = 1'b1;
      // mode dropped for one tail byte after the sequence: the match is forgotten
      h0 = hits;
      n = 0;
      repeat (6) put(SYNC_BYTE);
      copies(16);
      repeat (40) put(8'h5a);
      fork
         rx_source_inst.send(n, 2'b11, 0);
         begin
            repeat (110) @(posedge clk);
            #1 wake_en = 1'b0;
            @(posedge clk);
            #1 wake_en = 1'b1;
         end
      join
      `CHK(wake_alert, 1'b0)
      @(posedge clk);
      #1;
      `CHK(hits - h0, 0)
      $display("test off done");
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk);
      #1 rst_b = 1'b1;
      t_basic();
      t_refuse();
      t_restart();
      t_foreign();
      t_off();
      results();
   end
endmodule
